// [core/pin_ctl_pkg.sv]
package pin_ctl_pkg;
   // clock mode straps
   localparam int MODE_W = 3;
   localparam logic [2:0] MODE_RST = 3'h0;
   // machine clock: one machine cycle is this many mclk cycles
   localparam int MC_DIV = 2;
   // serial word length in bits
   localparam int WORD_W = 16;
   // bus wait logic
   localparam int WAIT_W = 3;
   localparam logic [2:0] WAIT_MIN_READY = 3'h2;
   // number of serial ports
   localparam int N_PORTS = 2;
   // AHB-Lite register map, byte addresses
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_CLKMD = 8'h04;
   localparam logic [7:0] OFF_SPDIR = 8'h08;
   localparam logic [7:0] OFF_STAT = 8'h0C;
   localparam logic [7:0] OFF_TXDATA = 8'h10;
   localparam logic [7:0] OFF_RXDATA = 8'h18;
   // CTRL fields
   localparam int CTRL_HPEN = 0;
   localparam int CTRL_WAIT_LSB = 4;
   // STAT fields
   localparam int STAT_HOLD = 0;
   localparam int STAT_TXBUSY = 4;
   localparam int STAT_RXDONE = 8;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   typedef enum logic [1:0] {
      BUS_IDLE, BUS_WAIT, BUS_READY, BUS_HOLD
   } bus_state_e;
endpackage

// [core/pin_ctl.sv]
// Contract
// - in hold, float bus lines and assert the grant output.
// - grant output driven high (not granted) while reset is active; code sets bus_grant_out high but holds bus_grant_oe low, so it floats.
// - with two or more waits, done strobe rises at last wait.
// - done looped to ready adds exactly one external wait state.
// - fetch flag low during instruction fetch address, else high.
// - machine clock out toggles per machine cycle, rising edge bounds.
// - straps captured into clock mode register while reset held.
// - software may rewrite clock mode; straps ignored until next reset.
// - timer a underflow gives one machine cycle pulse.
// - timer b underflow gives one machine cycle pulse.
// - timer b output shares host interrupt pin when host port off.
// - output disable low floats listed outputs.
// - oscillator drive output keeps driving under output disable.
// - serial clock and sync pins configurable, inputs after reset.
// - receive frame sync pulse starts word reception.
// - transmit frame sync pulse starts word transmission.
// - transmit data floats when idle, in reset, or output disabled.
// - receive and transmit clock pins shift the serial bits.
// - ready sampled only with two or more waits, after them.
//
// Our own choices: the AHB-Lite slave port and the address map.
`timescale 1ns/100ps
module pin_ctl
#(
   parameter int WORD_BITS = WORD_W
) (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // core side events
   input wire logic bus_access,
   input wire logic fetch_access,
   input wire logic timer_a_under,
   input wire logic timer_b_under,
   input wire logic host_irq,
   // pins
   input wire logic output_disable_n,
   input wire logic hold_request_n,
   input wire logic ready_in,
   input wire logic [2:0] clock_mode_straps,
   input wire logic oscillator_input,
   output logic oscillator_drive_out,
   output logic bus_grant_out,
   output logic bus_grant_oe,
   output logic bus_lines_oe,
   output logic wait_phase_done,
   output logic wait_phase_done_oe,
   output logic fetch_cycle_flag,
   output logic fetch_cycle_flag_oe,
   output logic machine_clock_out,
   output logic machine_clock_oe,
   output logic timer_a_pulse_out,
   output logic timer_a_oe,
   output logic host_interrupt_out,
   output logic host_interrupt_oe,
   // serial pins, one bit per port
   input wire logic [1:0] serial_rx_clock_i,
   output logic [1:0] serial_rx_clock_o,
   output logic [1:0] serial_rx_clock_oe,
   input wire logic [1:0] serial_rx_frame_sync_i,
   output logic [1:0] serial_rx_frame_sync_o,
   output logic [1:0] serial_rx_frame_sync_oe,
   input wire logic [1:0] serial_tx_clock_i,
   output logic [1:0] serial_tx_clock_o,
   output logic [1:0] serial_tx_clock_oe,
   input wire logic [1:0] serial_tx_frame_sync_i,
   output logic [1:0] serial_tx_frame_sync_o,
   output logic [1:0] serial_tx_frame_sync_oe,
   input wire logic [1:0] serial_rx_data_in,
   output logic [1:0] serial_tx_data_out,
   output logic [1:0] serial_tx_data_oe
);
   import pin_ctl_pkg::*;
   if (WORD_BITS < 2 || WORD_BITS > 32) begin
      $error("WORD_BITS out of range");
   end
   localparam int CW = $clog2(WORD_BITS + 1);
   // machine cycle divider
   logic mc_phase_q;
   logic mc_tick;
   logic [31:0] ctrl_q;
   logic [2:0] clkmd_q;
   logic [7:0] spdir_q;
   logic [WORD_BITS-1:0] txword_q [N_PORTS];
   logic [WORD_BITS-1:0] rxword_q [N_PORTS];
   logic [WORD_BITS-1:0] txsh_q [N_PORTS];
   logic [WORD_BITS-1:0] rxsh_q [N_PORTS];
   logic [CW-1:0] txcnt_q [N_PORTS];
   logic [CW-1:0] rxcnt_q [N_PORTS];
   logic [1:0] rxdone_q;
   logic [1:0] txbusy;
   logic [1:0] txclk_prev_q, rxclk_prev_q;
   logic [1:0] txfs_prev_q, rxfs_prev_q;
   logic [1:0] txclk, rxclk, txfs, rxfs;
   logic [1:0] int_clk_q;
   bus_state_e bus_q;
   logic [2:0] wcnt_q;
   logic hold_q;
   logic en;
   logic wr_pend_q;
   logic [7:0] wr_addr_q;
   logic [1:0] rd_clr;
   assign en = output_disable_n;
   assign mc_tick = mc_phase_q;
   assign hold_q = (bus_q == BUS_HOLD);
   always_ff @(posedge mclk) begin
      if (reset) begin
         mc_phase_q <= 1'b0;
      end else begin
         mc_phase_q <= ~mc_phase_q;
      end
   end
   // machine clock rises at the start of each machine cycle
   always_ff @(posedge mclk) begin
      if (reset) begin
         machine_clock_out <= 1'b0;
      end else begin
         machine_clock_out <= ~mc_phase_q;
      end
   end
   // straps caught by a clocked process while reset is held
   always_ff @(posedge mclk) begin
      if (reset) begin
         clkmd_q <= clock_mode_straps;
      end else if (wr_pend_q && wr_addr_q == OFF_CLKMD) begin
         clkmd_q <= hwdata[MODE_W-1:0];
      end
   end
   // ahb-lite slave: zero wait states, always OKAY
   always_ff @(posedge mclk) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (reset) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         hrdata <= 32'h0000_0000;
      end else begin
         wr_pend_q <= hsel && hready && htrans[1] && hwrite;
         wr_addr_q <= haddr;
         if (hsel && hready && htrans[1] && !hwrite) begin
            case (haddr)
               OFF_CTRL: hrdata <= ctrl_q;
               OFF_CLKMD: hrdata <= {29'h0, clkmd_q};
               OFF_SPDIR: hrdata <= {24'h0, spdir_q};
               OFF_STAT: hrdata <= {22'h0, rxdone_q[1], rxdone_q[0],
                  2'h0, txbusy, 3'h0, hold_q};
               OFF_TXDATA: hrdata <= 32'(txword_q[0]);
               OFF_TXDATA + 8'h04: hrdata <= 32'(txword_q[1]);
               OFF_RXDATA: hrdata <= 32'(rxword_q[0]);
               OFF_RXDATA + 8'h04: hrdata <= 32'(rxword_q[1]);
               default: hrdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         ctrl_q <= CTRL_RST;
         spdir_q <= 8'h00;
      end else if (wr_pend_q) begin
         if (wr_addr_q == OFF_CTRL) begin
            ctrl_q <= hwdata;
         end
         if (wr_addr_q == OFF_SPDIR) begin
            spdir_q <= hwdata[7:0];
         end
      end
   end

   always_ff @(posedge mclk) begin
      for (int p = 0; p < N_PORTS; p++) begin
         if (reset) begin
            txword_q[p] <= '0;
         end else if (wr_pend_q && wr_addr_q == OFF_TXDATA + 8'(4 * p)) begin
            txword_q[p] <= hwdata[WORD_BITS-1:0];
         end
      end
   end
   // bus wait and hold sequencer, stepped on machine cycles
   always_ff @(posedge mclk) begin
      if (reset) begin
         bus_q <= BUS_IDLE;
         wcnt_q <= 3'h0;
      end else if (mc_tick) begin
         case (bus_q)
            BUS_IDLE: begin
               if (!hold_request_n) begin
                  bus_q <= BUS_HOLD;
               end else if (bus_access) begin
                  wcnt_q <= ctrl_q[CTRL_WAIT_LSB +: WAIT_W];
                  bus_q <= (ctrl_q[CTRL_WAIT_LSB +: WAIT_W] == 3'h0) ?
                     BUS_IDLE : BUS_WAIT;
               end
            end
            BUS_WAIT: begin
               if (wcnt_q <= 3'h1) begin
                  wcnt_q <= 3'h0;
                  bus_q <= (ctrl_q[CTRL_WAIT_LSB +: WAIT_W] >= WAIT_MIN_READY)
                     ? BUS_READY : BUS_IDLE;
               end else begin
                  wcnt_q <= wcnt_q - 3'h1;
               end
            end
            BUS_READY: begin
               // a looped-back done strobe is still high here: one wait
               if (ready_in) begin
                  bus_q <= BUS_IDLE;
               end
            end
            BUS_HOLD: begin
               if (hold_request_n) begin
                  bus_q <= BUS_IDLE;
               end
            end
            default: bus_q <= BUS_IDLE;
         endcase
      end
   end
   // done strobe low through the waits, high from the last one
   always_ff @(posedge mclk) begin
      if (reset) begin
         wait_phase_done <= 1'b1;
      end else begin
         wait_phase_done <= !(bus_q == BUS_WAIT && wcnt_q > 3'h1 &&
            ctrl_q[CTRL_WAIT_LSB +: WAIT_W] >= WAIT_MIN_READY);
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         bus_grant_out <= 1'b1;
         fetch_cycle_flag <= 1'b1;
      end else begin
         bus_grant_out <= !hold_q;
         fetch_cycle_flag <= !(fetch_access && !hold_q);
      end
   end
   // timer pulses held for a whole machine cycle
   always_ff @(posedge mclk) begin
      if (reset) begin
         timer_a_pulse_out <= 1'b0;
         host_interrupt_out <= 1'b0;
      end else if (mc_tick) begin
         timer_a_pulse_out <= timer_a_under;
         host_interrupt_out <= ctrl_q[CTRL_HPEN] ? host_irq :
            timer_b_under;
      end
   end
   // enables: registered part only; disable input gates them next edge
   always_ff @(posedge mclk) begin
      if (reset) begin
         bus_grant_oe <= 1'b0;
         bus_lines_oe <= 1'b0;
         wait_phase_done_oe <= 1'b0;
         fetch_cycle_flag_oe <= 1'b0;
         machine_clock_oe <= 1'b0;
         timer_a_oe <= 1'b0;
         host_interrupt_oe <= 1'b0;
      end else begin
         bus_grant_oe <= en;
         bus_lines_oe <= en && !hold_q;
         wait_phase_done_oe <= en;
         fetch_cycle_flag_oe <= en;
         machine_clock_oe <= en;
         timer_a_oe <= en;
         host_interrupt_oe <= en;
      end
   end
   // oscillator drive ignores the disable input
   always_ff @(posedge mclk) begin
      if (reset) begin
         oscillator_drive_out <= 1'b0;
      end else begin
         oscillator_drive_out <= !oscillator_input;
      end
   end
   // internal serial clocks from the machine cycle when pins are outputs
   always_ff @(posedge mclk) begin
      if (reset) begin
         int_clk_q <= 2'h0;
      end else if (mc_tick) begin
         int_clk_q <= ~int_clk_q;
      end
   end

   always_comb begin
      for (int p = 0; p < N_PORTS; p++) begin
         rd_clr[p] = 1'b0;
         rxclk[p] = spdir_q[4*p] ? int_clk_q[p] : serial_rx_clock_i[p];
         rxfs[p] = spdir_q[4*p+1] ? 1'b0 : serial_rx_frame_sync_i[p];
         txclk[p] = spdir_q[4*p+2] ? int_clk_q[p] : serial_tx_clock_i[p];
         txfs[p] = spdir_q[4*p+3] ? (txcnt_q[p] == '0 && rd_clr[p]) :
            serial_tx_frame_sync_i[p];
         txbusy[p] = (txcnt_q[p] != '0);
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         txclk_prev_q <= 2'h0;
         rxclk_prev_q <= 2'h0;
         txfs_prev_q <= 2'h0;
         rxfs_prev_q <= 2'h0;
      end else begin
         txclk_prev_q <= txclk;
         rxclk_prev_q <= rxclk;
         txfs_prev_q <= txfs;
         rxfs_prev_q <= rxfs;
      end
   end
   // receive shifter on rising receive clock
   always_ff @(posedge mclk) begin
      for (int p = 0; p < N_PORTS; p++) begin
         if (reset) begin
            rxsh_q[p] <= '0;
            rxcnt_q[p] <= '0;
            rxword_q[p] <= '0;
            rxdone_q[p] <= 1'b0;
         end else if (rxclk[p] && !rxclk_prev_q[p]) begin
            if (rxfs[p] && rxcnt_q[p] == '0) begin
               rxcnt_q[p] <= CW'(WORD_BITS);
               rxdone_q[p] <= 1'b0;
            end else if (rxcnt_q[p] != '0) begin
               rxsh_q[p] <= {rxsh_q[p][WORD_BITS-2:0], serial_rx_data_in[p]};
               rxcnt_q[p] <= rxcnt_q[p] - CW'(1);
               if (rxcnt_q[p] == CW'(1)) begin
                  rxword_q[p] <= {rxsh_q[p][WORD_BITS-2:0],
                     serial_rx_data_in[p]};
                  rxdone_q[p] <= 1'b1;
               end
            end
         end
      end
   end
   // transmit shifter, msb first, on rising transmit clock
   always_ff @(posedge mclk) begin
      for (int p = 0; p < N_PORTS; p++) begin
         if (reset) begin
            txsh_q[p] <= '0;
            txcnt_q[p] <= '0;
         end else if (txclk[p] && !txclk_prev_q[p]) begin
            if (txfs[p] && txcnt_q[p] == '0) begin
               txsh_q[p] <= txword_q[p];
               txcnt_q[p] <= CW'(WORD_BITS);
            end else if (txcnt_q[p] != '0) begin
               txsh_q[p] <= {txsh_q[p][WORD_BITS-2:0], 1'b0};
               txcnt_q[p] <= txcnt_q[p] - CW'(1);
            end
         end
      end
   end

   always_ff @(posedge mclk) begin
      for (int p = 0; p < N_PORTS; p++) begin
         if (reset) begin
            serial_tx_data_out[p] <= 1'b0;
            serial_tx_data_oe[p] <= 1'b0;
            serial_rx_clock_o[p] <= 1'b0;
            serial_rx_frame_sync_o[p] <= 1'b0;
            serial_tx_clock_o[p] <= 1'b0;
            serial_tx_frame_sync_o[p] <= 1'b0;
            serial_rx_clock_oe[p] <= 1'b0;
            serial_rx_frame_sync_oe[p] <= 1'b0;
            serial_tx_clock_oe[p] <= 1'b0;
            serial_tx_frame_sync_oe[p] <= 1'b0;
         end else begin
            serial_tx_data_out[p] <= txsh_q[p][WORD_BITS-1];
            serial_tx_data_oe[p] <= en && txbusy[p];
            serial_rx_clock_o[p] <= int_clk_q[p];
            serial_rx_frame_sync_o[p] <= 1'b0;
            serial_tx_clock_o[p] <= int_clk_q[p];
            serial_tx_frame_sync_o[p] <= txfs[p];
            serial_rx_clock_oe[p] <= spdir_q[4*p];
            serial_rx_frame_sync_oe[p] <= spdir_q[4*p+1];
            serial_tx_clock_oe[p] <= en && spdir_q[4*p+2];
            serial_tx_frame_sync_oe[p] <= en && spdir_q[4*p+3];
         end
      end
   end
endmodule

// [test/pin_ctl_sva.sv]
`timescale 1ns/100ps
module pin_ctl_chk (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // inputs watched
   input wire logic output_disable_n,
   input wire logic hold_request_n,
   input wire logic bus_access,
   input wire logic fetch_access,
   input wire logic oscillator_input,
   // outputs watched
   input wire logic oscillator_drive_out,
   input wire logic bus_grant_out,
   input wire logic bus_grant_oe,
   input wire logic bus_lines_oe,
   input wire logic fetch_cycle_flag,
   input wire logic machine_clock_out,
   input wire logic machine_clock_oe,
   input wire logic timer_a_pulse_out,
   input wire logic timer_a_oe,
   input wire logic [1:0] serial_rx_clock_oe,
   input wire logic [1:0] serial_tx_clock_oe,
   input wire logic [1:0] serial_tx_frame_sync_oe,
   input wire logic [1:0] serial_tx_data_oe
);
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   // reset itself is the cause here, so these two stay armed
   chk_grant_reset: assert property (
      disable iff (1'h0) reset |=> bus_grant_out)
      else $error("grant not high after reset edge");
   chk_dir_reset: assert property (
      disable iff (1'h0) reset |=> serial_rx_clock_oe == 2'h0
         && serial_tx_clock_oe == 2'h0 && serial_tx_data_oe == 2'h0)
      else $error("serial pin driven after reset edge");
   chk_hold_grant: assert property (
      $fell(hold_request_n) && !bus_access |-> ##[1:8] !bus_grant_out)
      else $error("hold request not granted in time");
   chk_hold_float: assert property (
      !bus_grant_out |-> !bus_lines_oe)
      else $error("bus lines driven while granted");
   chk_odis_float: assert property (
      !output_disable_n |=> !bus_grant_oe && !machine_clock_oe
         && !timer_a_oe && serial_tx_clock_oe == 2'h0
         && serial_tx_frame_sync_oe == 2'h0 && serial_tx_data_oe == 2'h0)
      else $error("output driven while disabled");
   chk_odis_back: assert property (
      $rose(output_disable_n) |=> bus_grant_oe && machine_clock_oe)
      else $error("outputs not back after disable");
   chk_osc_drive: assert property (
      1'h1 |=> oscillator_drive_out == !$past(oscillator_input))
      else $error("oscillator drive not inverse of input");
   chk_fetch_flag: assert property (
      1'h1 |=> fetch_cycle_flag == !$past(fetch_access))
      else $error("fetch flag wrong");
   chk_mclk_period: assert property (
      $rose(machine_clock_out) |=> !machine_clock_out ##1 machine_clock_out)
      else $error("machine clock period wrong");
   chk_timer_pulse: assert property (
      $rose(timer_a_pulse_out) |=> timer_a_pulse_out ##1 !timer_a_pulse_out)
      else $error("timer pulse width wrong");
   cov_grant: cover property (!bus_grant_out);
   cov_timer: cover property ($rose(timer_a_pulse_out));
   cov_odis: cover property ($rose(output_disable_n));
endmodule

bind pin_ctl pin_ctl_chk i_chk (
   .mclk, .reset, .output_disable_n, .hold_request_n, .bus_access,
   .fetch_access, .oscillator_input, .oscillator_drive_out,
   .bus_grant_out, .bus_grant_oe, .bus_lines_oe, .fetch_cycle_flag,
   .machine_clock_out, .machine_clock_oe, .timer_a_pulse_out,
   .timer_a_oe, .serial_rx_clock_oe, .serial_tx_clock_oe,
   .serial_tx_frame_sync_oe, .serial_tx_data_oe
);

// [test/hold_master.sv]
`timescale 1ns/100ps
module hold_master (
   // clock
   input wire logic mclk,
   // bench control
   input wire logic want_bus,
   // pins
   input wire logic bus_grant_out,
   input wire logic bus_lines_oe,
   output logic hold_request_n,
   output logic owns_bus
);
   initial hold_request_n = 1'h1;
   always @(posedge mclk) begin
      hold_request_n <= !want_bus;
   end
   // only drive once granted and the device has let go of the lines
   assign owns_bus = !hold_request_n && !bus_grant_out
      && !bus_lines_oe;
endmodule

// [test/dsp_pin_signalling_control_tb_top.sv]
`timescale 1ns/100ps
module dsp_pin_signalling_control_tb_top;
   import pin_ctl_pkg::*;
`define CHK(g, e) cmp(32'(g), 32'(e))
   localparam int LIM = 64;
   logic mclk = 1'h0, reset = 1'h1, hsel = 1'h0, hwrite = 1'h0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2, clock_mode_straps = 3'h5;
   logic [31:0] hwdata = 32'h0;
   logic bus_access = 1'h0, fetch_access = 1'h0, timer_a_under = 1'h0;
   logic timer_b_under = 1'h0, host_irq = 1'h0, output_disable_n = 1'h1;
   logic oscillator_input = 1'h0, want_bus = 1'h0;
   logic [1:0] serial_rx_clock_i = 2'h0, serial_rx_frame_sync_i = 2'h0;
   logic [1:0] serial_tx_clock_i = 2'h0, serial_tx_frame_sync_i = 2'h0;
   logic [1:0] serial_rx_data_in = 2'h0;
   wire logic [31:0] hrdata;
   wire logic hreadyout, hresp, hold_request_n, owns_bus, ready_in;
   wire logic oscillator_drive_out, bus_grant_out, bus_grant_oe;
   wire logic bus_lines_oe, wait_phase_done, wait_phase_done_oe;
   wire logic fetch_cycle_flag, fetch_cycle_flag_oe, machine_clock_out;
   wire logic machine_clock_oe, timer_a_pulse_out, timer_a_oe;
   wire logic host_interrupt_out, host_interrupt_oe;
   wire logic [1:0] serial_rx_clock_o, serial_rx_clock_oe;
   wire logic [1:0] serial_rx_frame_sync_o, serial_rx_frame_sync_oe;
   wire logic [1:0] serial_tx_clock_o, serial_tx_clock_oe;
   wire logic [1:0] serial_tx_frame_sync_o, serial_tx_frame_sync_oe;
   wire logic [1:0] serial_tx_data_out, serial_tx_data_oe;
   int bad_count = 0, checks = 0;
   typedef struct {
      logic [7:0] a;
      logic [31:0] w;
      logic [31:0] r;
   } row_s;
   row_s rows [5] = '{'{OFF_CTRL, 32'h31, 32'h31},
      '{OFF_CLKMD, 32'h3, 32'h3}, '{OFF_SPDIR, 32'hFF, 32'hFF},
      '{8'h40, 32'hDEAD, 32'h0}, '{OFF_CTRL, 32'h0, 32'h0}};

   always #12.5 mclk = !mclk;
   // never lands on a rising edge of mclk
   always #40 oscillator_input = !oscillator_input;
   // strobe looped back to ready
   assign ready_in = wait_phase_done;

   pin_ctl i_dut (
      .mclk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .bus_access,
      .fetch_access, .timer_a_under, .timer_b_under, .host_irq,
      .output_disable_n, .hold_request_n, .ready_in, .clock_mode_straps,
      .oscillator_input, .oscillator_drive_out, .bus_grant_out,
      .bus_grant_oe, .bus_lines_oe, .wait_phase_done, .wait_phase_done_oe,
      .fetch_cycle_flag, .fetch_cycle_flag_oe, .machine_clock_out,
      .machine_clock_oe, .timer_a_pulse_out, .timer_a_oe,
      .host_interrupt_out, .host_interrupt_oe, .serial_rx_clock_i,
      .serial_rx_clock_o, .serial_rx_clock_oe, .serial_rx_frame_sync_i,
      .serial_rx_frame_sync_o, .serial_rx_frame_sync_oe,
      .serial_tx_clock_i, .serial_tx_clock_o, .serial_tx_clock_oe,
      .serial_tx_frame_sync_i, .serial_tx_frame_sync_o,
      .serial_tx_frame_sync_oe, .serial_rx_data_in, .serial_tx_data_out,
      .serial_tx_data_oe
   );

   hold_master i_master (
      .mclk, .want_bus, .bus_grant_out, .bus_lines_oe, .hold_request_n,
      .owns_bus
   );

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic lim(input int n);
      if (n >= LIM) begin
         bad_count++;
         stop_test();
      end
   endtask

   task automatic ahb(input logic wr, input logic [7:0] a,
         input logic [31:0] wd, output logic [31:0] rd);
      int n;
      @(posedge mclk);
      hsel <= 1'h1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      for (n = 0; n == 0 || (hreadyout !== 1'h1 && n < LIM); n++)
         @(posedge mclk);
      lim(n);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= wd;
      for (n = 0; n == 0 || (hreadyout !== 1'h1 && n < LIM); n++)
         @(posedge mclk);
      lim(n);
      rd = hrdata;
   endtask

   initial begin
      logic [31:0] rd;
      logic seen;
      int n;
      repeat (8) @(posedge mclk);
      reset <= 1'h0;
      foreach (rows[i]) begin
         ahb(1'h1, rows[i].a, rows[i].w, rd);
         ahb(1'h0, rows[i].a, 32'h0, rd);
         `CHK(rd, rows[i].r);
      end
      @(posedge mclk);
      reset <= 1'h1;
      clock_mode_straps <= 3'h6;
      repeat (8) @(negedge mclk);
      `CHK(bus_grant_out, 1'h1);
      `CHK(serial_tx_data_oe, 2'h0);
      @(posedge mclk);
      reset <= 1'h0;
      ahb(1'h0, OFF_CLKMD, 32'h0, rd);
      `CHK(rd, 32'h6);
      clock_mode_straps <= 3'h1;
      ahb(1'h0, OFF_CLKMD, 32'h0, rd);
      `CHK(rd, 32'h6);
      ahb(1'h1, OFF_SPDIR, 32'hFF, rd);
      repeat (2) @(negedge mclk);
      `CHK({serial_rx_clock_oe, serial_tx_frame_sync_oe}, 4'hF);
      ahb(1'h1, OFF_SPDIR, 32'h0, rd);
      repeat (2) @(negedge mclk);
      `CHK({serial_rx_clock_oe, serial_tx_frame_sync_oe}, 4'h0);
      @(posedge mclk);
      output_disable_n <= 1'h0;
      repeat (3) @(negedge mclk);
      `CHK({bus_grant_oe, wait_phase_done_oe, fetch_cycle_flag_oe,
         host_interrupt_oe}, 4'h0);
      @(posedge mclk);
      output_disable_n <= 1'h1;
      want_bus <= 1'h1;
      repeat (2) @(negedge mclk);
      `CHK({bus_grant_oe, fetch_cycle_flag_oe}, 2'h3);
      for (n = 0; n < LIM && owns_bus !== 1'h1; n++) @(negedge mclk);
      lim(n);
      `CHK({bus_grant_out, bus_lines_oe}, 2'h0);
      ahb(1'h0, OFF_STAT, 32'h0, rd);
      `CHK(rd[STAT_HOLD], 1'h1);
      want_bus <= 1'h0;
      for (n = 0; n < LIM && bus_grant_out !== 1'h1; n++) @(negedge mclk);
      lim(n);
      @(posedge mclk);
      timer_a_under <= 1'h1;
      timer_b_under <= 1'h1;
      fetch_access <= 1'h1;
      repeat (MC_DIV) @(posedge mclk);
      timer_a_under <= 1'h0;
      timer_b_under <= 1'h0;
      fetch_access <= 1'h0;
      @(negedge mclk);
      `CHK(fetch_cycle_flag, 1'h0);
      for (n = 0; n < LIM && host_interrupt_out !== 1'h1; n++)
         @(negedge mclk);
      lim(n);
      for (n = 0; n < LIM && host_interrupt_out === 1'h1; n++)
         @(negedge mclk);
      lim(n);
      `CHK(n, MC_DIV);
      ahb(1'h1, OFF_CTRL, 32'h31, rd);
      host_irq <= 1'h1;
      repeat (4) @(negedge mclk);
      `CHK(host_interrupt_out, 1'h1);
      @(posedge mclk);
      host_irq <= 1'h0;
      timer_b_under <= 1'h1;
      repeat (4) @(negedge mclk);
      `CHK(host_interrupt_out, 1'h0);
      @(posedge mclk);
      timer_b_under <= 1'h0;
      bus_access <= 1'h1;
      for (n = 0; n < LIM && wait_phase_done !== 1'h0; n++) @(negedge mclk);
      lim(n);
      @(posedge mclk);
      bus_access <= 1'h0;
      for (n = 0; n < LIM && wait_phase_done !== 1'h1; n++) @(negedge mclk);
      lim(n);
      `CHK(n > 0, 1'h1);
      ahb(1'h1, OFF_TXDATA, 32'hA5C3, rd);
      `CHK(serial_tx_data_oe, 2'h0);
      seen = 1'h0;
      // link clocks run through all 96 cycles; frame sync only for the first 4
      for (int i = 0; i < 96; i++) begin
         @(posedge mclk);
         serial_tx_clock_i[0] <= i[1];
         serial_rx_clock_i[0] <= i[1];
         serial_tx_frame_sync_i[0] <= (i < 4);
         serial_rx_frame_sync_i[0] <= (i < 4);
         // transmit data looped into the receiver
         serial_rx_data_in[0] <= serial_tx_data_out[0];
         if (serial_tx_data_oe[0] === 1'h1)
            seen = 1'h1;
      end
      `CHK(seen, 1'h1);
      repeat (2) @(negedge mclk);
      `CHK(serial_tx_data_oe, 2'h0);
      ahb(1'h0, OFF_STAT, 32'h0, rd);
      `CHK(rd[STAT_RXDONE], 1'h1);
      ahb(1'h0, OFF_RXDATA, 32'h0, rd);
      `CHK(rd, 32'hA5C3);
      stop_test();
   end
endmodule
